// ### logic/ild_regs.svh
`ifndef ILD_REGS_SVH
`define ILD_REGS_SVH
// Register offsets on the plain register port
`define ILD_OFS_SRC_EN 8'h00
`define ILD_OFS_GLOBAL 8'h04
`define ILD_OFS_PRIO 8'h08
`define ILD_OFS_STATE 8'h0C
`define ILD_OFS_INT_STAT 8'h10
`define ILD_OFS_INT_CLR 8'h14
`define ILD_OFS_INT_EN 8'h18
// Reset values
`define ILD_RST_SRC_EN 17'h0_0000
`define ILD_RST_PRIO 17'h0_0000
`define ILD_RST_INT_EN 3'h0
// Field positions
`define ILD_GLOBAL_BIT 0
`define ILD_EVT_VECTORED 0
`define ILD_EVT_STALLED 1
`define ILD_EVT_RETURNED 2
// Vector map
`define ILD_VEC_RESET 16'h0000
`define ILD_VEC_BASE 16'h0003
`define ILD_VEC_STEP 16'h0008
`define ILD_SPI_IDX 6
// Sources whose pending flag is cleared on vectoring
`define ILD_AUTO_CLR_MASK 17'h0_000F
// Timing counts in system clocks
`define ILD_DETECT_CYCLES 1
`define ILD_CALL_CYCLES 5
`endif

// ### logic/ild_pkg.sv
package ild_pkg;
    // Core pipeline status, all from logic on the same clock
    typedef struct packed {
        logic instr_done;
        logic return_from_interrupt_instr_done;
        logic stall;
    } ild_core_type;
    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ild_bus_type;
    typedef enum logic [0:0] {
        ILD_IDLE,
        ILD_CALL
    } ild_state_type;
endpackage

// ### logic/ild_dispatch.sv
`timescale 1ns/10ps
`include "ild_regs.svh"
module ild_dispatch #(
    parameter int NUM_SRC = 17
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire ild_pkg::ild_bus_type bus,
    output logic [31:0] rdata_ff,
    // Peripheral pending flags
    input wire logic [NUM_SRC-1:0] src_pending,
    input wire logic spi_transfer_done_flag,
    input wire logic spi_write_collision_flag,
    input wire logic spi_mode_fault_flag,
    input wire logic spi_rx_overrun_flag,
    // Core pipeline
    input wire ild_pkg::ild_core_type core,
    output logic call_active_ff,
    output logic call_done_ff,
    output logic [15:0] call_vector_ff,
    output logic [NUM_SRC-1:0] hw_clear_ff,
    // Interrupt to the system
    output logic irq_ff
);

    // Winner among candidates: high level first, then lowest index
    function automatic logic [5:0] pick(input logic [NUM_SRC-1:0] cand_hi,
                                        input logic [NUM_SRC-1:0] cand_lo);
        logic [5:0] res;
        logic found;
        res = 6'h00;
        found = 1'b0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (cand_hi[i] && !found) begin
                res = 6'(i);
                found = 1'b1;
            end
        end
        for (int i = 0; i < NUM_SRC; i++) begin
            if (cand_lo[i] && !found) begin
                res = 6'(i);
                found = 1'b1;
            end
        end
        return res;
    endfunction

    // Fixed vector from the source index
    function automatic logic [15:0] vec_of(input logic [5:0] idx);
        return `ILD_VEC_BASE + 16'({10'h000, idx} * `ILD_VEC_STEP);
    endfunction

    logic [NUM_SRC-1:0] src_en_ff;
    logic global_en_ff;
    logic [NUM_SRC-1:0] prio_ff;
    logic [2:0] int_stat_ff;
    logic [2:0] int_en_ff;
    logic act_hi_ff;
    logic act_lo_ff;
    logic req_valid_ff;
    logic req_hi_ff;
    logic [5:0] req_idx_ff;
    logic [2:0] cnt_ff;
    logic [2:0] nxt_cnt;
    ild_pkg::ild_state_type state_ff;
    ild_pkg::ild_state_type nxt_state;
    logic [NUM_SRC-1:0] pend;
    logic [NUM_SRC-1:0] cand;
    logic [NUM_SRC-1:0] cand_hi;
    logic [NUM_SRC-1:0] cand_lo;
    logic take;
    logic [2:0] evt;

    // SPI flags fold into one source request
    always_comb begin
        pend = src_pending;
        pend[`ILD_SPI_IDX] = src_pending[`ILD_SPI_IDX] | spi_transfer_done_flag
            | spi_write_collision_flag | spi_mode_fault_flag | spi_rx_overrun_flag;
    end

    // Masking and preemption filter
    always_comb begin
        cand = pend & src_en_ff & {NUM_SRC{global_en_ff}};
        cand_hi = cand & prio_ff & {NUM_SRC{!act_hi_ff}};
        cand_lo = cand & ~prio_ff & {NUM_SRC{!act_hi_ff && !act_lo_ff}};
    end

    // Detect stage: one clock of sampling before any call can start
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            req_valid_ff <= 1'b0;
            req_hi_ff <= 1'b0;
            req_idx_ff <= 6'h00;
        end else begin
            req_valid_ff <= |(cand_hi | cand_lo);
            req_hi_ff <= |cand_hi;
            req_idx_ff <= pick(cand_hi, cand_lo);
        end
    end

    // Vectoring only at an instruction boundary; the one after a return is skipped
    // so that at least one further instruction runs before the call.
    always_comb begin
        take = (state_ff == ild_pkg::ILD_IDLE) && req_valid_ff && core.instr_done
            && !core.return_from_interrupt_instr_done && !core.stall;
    end

    // Call sequencer
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        unique case (state_ff)
            ild_pkg::ILD_IDLE: begin
                if (take) begin
                    nxt_state = ild_pkg::ILD_CALL;
                    nxt_cnt = 3'(`ILD_CALL_CYCLES - 1);
                end
            end
            ild_pkg::ILD_CALL: begin
                // Stall freezes the call, stretching latency by its length
                if (!core.stall) begin
                    if (cnt_ff == 3'h0) begin
                        nxt_state = ild_pkg::ILD_IDLE;
                    end else begin
                        nxt_cnt = cnt_ff - 3'h1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_ff <= ild_pkg::ILD_IDLE;
            cnt_ff <= 3'h0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    // Call outputs; vector points at reset location until first call
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            call_active_ff <= 1'b0;
            call_done_ff <= 1'b0;
            call_vector_ff <= `ILD_VEC_RESET;
            hw_clear_ff <= '0;
        end else begin
            call_active_ff <= (nxt_state == ild_pkg::ILD_CALL);
            call_done_ff <= (state_ff == ild_pkg::ILD_CALL)
                && (nxt_state == ild_pkg::ILD_IDLE);
            hw_clear_ff <= '0;
            if (take) begin
                call_vector_ff <= vec_of(req_idx_ff);
                // Only edge-style sources are cleared; others stay for software
                hw_clear_ff <= NUM_SRC'(`ILD_AUTO_CLR_MASK)
                    & (NUM_SRC'(1) << req_idx_ff);
            end
        end
    end

    // Priority level in service; a return retires the higher one first
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            act_hi_ff <= 1'b0;
            act_lo_ff <= 1'b0;
        end else if (take) begin
            if (req_hi_ff) begin
                act_hi_ff <= 1'b1;
            end else begin
                act_lo_ff <= 1'b1;
            end
        end else if (core.return_from_interrupt_instr_done && core.instr_done) begin
            if (act_hi_ff) begin
                act_hi_ff <= 1'b0;
            end else begin
                act_lo_ff <= 1'b0;
            end
        end
    end

    // Software writes
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            src_en_ff <= NUM_SRC'(`ILD_RST_SRC_EN);
            global_en_ff <= 1'b0;
            prio_ff <= NUM_SRC'(`ILD_RST_PRIO);
            int_en_ff <= `ILD_RST_INT_EN;
        end else if (bus.wr) begin
            unique case (bus.addr)
                `ILD_OFS_SRC_EN: src_en_ff <= bus.wdata[NUM_SRC-1:0];
                `ILD_OFS_GLOBAL: global_en_ff <= bus.wdata[`ILD_GLOBAL_BIT];
                `ILD_OFS_PRIO: prio_ff <= bus.wdata[NUM_SRC-1:0];
                `ILD_OFS_INT_EN: int_en_ff <= bus.wdata[2:0];
                default: ;
            endcase
        end
    end

    // Events for the system interrupt
    always_comb begin
        evt = 3'h0;
        evt[`ILD_EVT_VECTORED] = take;
        evt[`ILD_EVT_STALLED] = core.stall && req_valid_ff
            && (state_ff == ild_pkg::ILD_IDLE);
        evt[`ILD_EVT_RETURNED] = core.return_from_interrupt_instr_done && core.instr_done;
    end

    // Sticky status; a new event beats a clear in the same cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            int_stat_ff <= 3'h0;
        end else begin
            if (bus.wr && bus.addr == `ILD_OFS_INT_CLR) begin
                int_stat_ff <= (int_stat_ff & ~bus.wdata[2:0]) | evt;
            end else begin
                int_stat_ff <= int_stat_ff | evt;
            end
        end
    end

    // Level interrupt, registered so it lags the status by one clock
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(int_stat_ff & int_en_ff);
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_ff <= 32'h0000_0000;
        end else begin
            rdata_ff <= 32'h0000_0000;
            if (bus.rd) begin
                unique case (bus.addr)
                    `ILD_OFS_SRC_EN: rdata_ff <= 32'(src_en_ff);
                    `ILD_OFS_GLOBAL: rdata_ff <= 32'(global_en_ff);
                    `ILD_OFS_PRIO: rdata_ff <= 32'(prio_ff);
                    `ILD_OFS_STATE: rdata_ff <= {call_vector_ff, 8'h00,
                        req_valid_ff, req_hi_ff, req_idx_ff[3:0] == 4'h0 ? 1'b0 : 1'b1,
                        1'b0, call_active_ff, act_hi_ff, act_lo_ff,
                        (state_ff == ild_pkg::ILD_CALL)};
                    `ILD_OFS_INT_STAT: rdata_ff <= 32'(int_stat_ff);
                    `ILD_OFS_INT_EN: rdata_ff <= 32'(int_en_ff);
                    default: rdata_ff <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule

// ### testbench/ild_dispatch_checker.sv
`timescale 1ns/10ps
module ild_dispatch_checker #(
    parameter int NUM_SRC = 17
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Watched ports
    input wire ild_pkg::ild_bus_type bus,
    input wire logic [31:0] rdata_ff,
    input wire ild_pkg::ild_core_type core,
    input wire logic call_active_ff,
    input wire logic call_done_ff,
    input wire logic [15:0] call_vector_ff,
    input wire logic [NUM_SRC-1:0] hw_clear_ff
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Call length and completion; a stall may only stretch it
    property p_call_len;
        $rose(call_active_ff) |-> call_active_ff[*5];
    endproperty
    a_call_len: assert property (p_call_len) else $error("call too short");
    property p_done;
        $fell(call_active_ff) |-> call_done_ff ##1 !call_done_ff;
    endproperty
    a_done: assert property (p_done) else $error("call end pulse wrong");
    // Calls start only at an ordinary instruction boundary
    property p_boundary;
        $rose(call_active_ff) |-> $past(core.instr_done && !core.return_from_interrupt_instr_done);
    endproperty
    a_boundary: assert property (p_boundary) else $error("call off boundary");
    property p_return_from_interrupt_instr;
        core.return_from_interrupt_instr_done |=> !$rose(call_active_ff);
    endproperty
    a_return_from_interrupt_instr: assert property (p_return_from_interrupt_instr) else $error("call right after return");
    property p_stall;
        call_active_ff && core.stall |=> call_active_ff;
    endproperty
    a_stall: assert property (p_stall) else $error("call ran on in stall");
    property p_vec;
        $rose(call_active_ff) |-> call_vector_ff[2:0] == 3'h3 && call_vector_ff <= 16'h0083;
    endproperty
    a_vec: assert property (p_vec) else $error("bad vector");
    // Flag clear pulse only for the low four sources, matching the vector
    property p_hwclr;
        |hw_clear_ff |-> $rose(call_active_ff) && call_vector_ff < 16'h0023
            && hw_clear_ff == (1 << call_vector_ff[6:3]);
    endproperty
    a_hwclr: assert property (p_hwclr) else $error("bad flag clear");
    property p_rdata;
        !bus.rd |=> rdata_ff == 32'h0000_0000;
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data outside slot");
endmodule
bind ild_dispatch ild_dispatch_checker #(.NUM_SRC(NUM_SRC)) ild_dispatch_checker_inst (.*);

// ### testbench/ild_core_model.sv
`timescale 1ns/10ps
module ild_core_model (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Bench commands
    input wire logic ret_req,
    input wire logic stall_req,
    // Dispatcher side
    input wire logic call_active_ff,
    output ild_pkg::ild_core_type core
);
    // One instruction per clock outside calls; stalls give the slow answer
    always_comb begin
        core.stall = stall_req;
        core.instr_done = !reset && !stall_req && !call_active_ff;
        core.return_from_interrupt_instr_done = core.instr_done && ret_req;
    end
endmodule

// ### testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
    logic clk, reset, ret_req, stall_req, call_active_ff, call_done_ff, irq_ff;
    logic [3:0] spi;
    logic [16:0] src_pending, hw_clear_ff;
    logic [15:0] call_vector_ff;
    logic [31:0] rdata_ff;
    ild_pkg::ild_bus_type bus;
    ild_pkg::ild_core_type core;
    int mismatches, checks, cycles, a, b;
    integer seed = 32'h68b9_b18d;
    ild_dispatch #(.NUM_SRC(17)) ild_dispatch_inst (.clk(clk), .reset(reset), .bus(bus),
        .rdata_ff(rdata_ff), .src_pending(src_pending), .spi_transfer_done_flag(spi[0]),
        .spi_write_collision_flag(spi[1]), .spi_mode_fault_flag(spi[2]),
        .spi_rx_overrun_flag(spi[3]), .core(core), .call_active_ff(call_active_ff),
        .call_done_ff(call_done_ff), .call_vector_ff(call_vector_ff),
        .hw_clear_ff(hw_clear_ff), .irq_ff(irq_ff));
    ild_core_model ild_core_model_inst (.clk(clk), .reset(reset), .ret_req(ret_req),
        .stall_req(stall_req), .call_active_ff(call_active_ff), .core(core));
    // Expected vector and flag clear per source
    function automatic logic [15:0] vec(input int i);
        return 16'h0003 + 16'h0008 * i[15:0];
    endfunction
    function automatic logic [16:0] clr(input int i);
        return (i < 4) ? 17'h0_0001 << i : 17'h0_0000;
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Bus tasks start and end on a rising edge
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        bus <= '{ad, d, 1'b1, 1'b0};
        @(posedge clk);
        bus <= '{ad, d, 1'b0, 1'b0};
        @(posedge clk); // Idle edge, so the next task never re-drives bus in this step
    endtask
    task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
        bus <= '{ad, 32'h0000_0000, 1'b0, 1'b1};
        @(posedge clk);
        bus <= '{ad, 32'h0000_0000, 1'b0, 1'b0};
        #1 check(rdata_ff, exp);
        @(posedge clk);
    endtask
    // Raise requests, optionally a return or a stall after detect, then await the call
    task automatic serve(input logic [20:0] p, input int i, input int m, input int l);
        int n;
        {spi, src_pending} <= p;
        @(posedge clk);
        n = 1;
        if (m == 1) begin
            ret_req <= 1'b1;
            @(posedge clk);
            ret_req <= 1'b0;
            n = 2;
        end
        if (m > 1) begin
            stall_req <= 1'b1;
            repeat (m) @(posedge clk);
            stall_req <= 1'b0;
            n = 1 + m;
        end
        // Latency counts the detect edge and the vectoring edge, plus return or stall
        #1;
        while (call_active_ff !== 1'b1 && n < 60) begin
            @(posedge clk);
            #1 n++;
        end
        if (l > 0) check(n, l);
        check(call_vector_ff, vec(i));
        check(hw_clear_ff, clr(i));
        @(posedge clk);
        {spi, src_pending} <= 21'h00_0000;
        repeat (6) @(posedge clk);
    endtask
    task automatic ret();
        ret_req <= 1'b1;
        @(posedge clk);
        ret_req <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic print_verdict();
        if (mismatches == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Hang guard, far above the few hundred clocks that the 21 calls take
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            print_verdict();
        end
    end
    initial begin
        {reset, ret_req, stall_req} = 3'h4;
        {spi, src_pending} = 21'h00_0000;
        bus = '0;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd(8'h00, 32'h0000_0000);
        rd(8'h08, 32'h0000_0000);
        rd(8'h18, 32'h0000_0000);
        rd(8'h1C, 32'h0000_0000);
        wr(8'h00, 32'h0001_FFFF);
        wr(8'h18, 32'h0000_0007);
        src_pending <= 17'h1_FFFF;
        repeat (8) @(posedge clk);
        check(call_active_ff, 1'b0);
        src_pending <= 17'h0_0000;
        wr(8'h04, 32'h0000_0001);
        rd(8'h04, 32'h0000_0001);
        serve(21'h00_0001, 0, 0, 2);
        ret();
        serve(21'h01_0000, 16, 1, 3);
        ret();
        serve(21'h00_0004, 2, 5, 7);
        ret();
        for (a = 0; a < 4; a++) begin
            serve(21'h02_0000 << a, 6, 0, 2);
            ret();
        end
        serve(21'h00_0120, 5, 0, 2);
        ret();
        wr(8'h08, 32'h0000_0100);
        rd(8'h08, 32'h0000_0100);
        serve(21'h00_0120, 8, 0, 2);
        src_pending <= 17'h0_0020;
        repeat (8) @(posedge clk);
        check(call_active_ff, 1'b0);
        ret();
        serve(21'h00_0020, 5, 0, 0);
        serve(21'h00_0100, 8, 0, 2);
        ret();
        ret();
        wr(8'h08, 32'h0000_0000);
        for (a = 0; a < 10; a++) begin
            b = $unsigned($random(seed)) % 17;
            serve(21'h00_0001 << b, b, 0, 2);
            ret();
        end
        rd(8'h10, 32'h0000_0007);
        check(irq_ff, 1'b1);
        // Status ignores writes; only the clear register drops bits
        wr(8'h10, 32'h0000_0007);
        rd(8'h10, 32'h0000_0007);
        wr(8'h14, 32'h0000_0007);
        rd(8'h10, 32'h0000_0000);
        check(irq_ff, 1'b0);
        wr(8'h18, 32'h0000_0000);
        print_verdict();
    end
endmodule
